// [logic/twh_pkg.sv]
// Package: constants and carriers for the table write holding unit
package twh_pkg;
   localparam int PTR_W   = 21;
   localparam int SEL_W   = 3;
   localparam int DATA_W  = 8;
   localparam int HOLD_N  = 8;
   localparam int OPC_W   = 16;
   localparam logic [OPC_W-1:0] OPC_MASK  = 16'hFFFC;
   localparam logic [OPC_W-1:0] OPC_MATCH = 16'h000C;
   localparam logic [1:0] MODE_NONE = 2'h0;
   localparam logic [1:0] MODE_PINC = 2'h1;
   localparam logic [1:0] MODE_PDEC = 2'h2;
   localparam logic [1:0] MODE_PRE  = 2'h3;
   localparam logic [PTR_W-1:0] PTR_RST  = 21'h000000;
   localparam logic [PTR_W-1:0] PTR_ONE  = 21'h000001;
   localparam logic [DATA_W-1:0] HOLD_RST = 8'hFF;

   typedef struct packed {
      logic             valid;
      logic [OPC_W-1:0] opcode;
   } twh_instr_t;

   typedef struct packed {
      logic              load;
      logic [PTR_W-1:0]  value;
   } twh_ptr_load_t;

   typedef struct packed {
      logic              valid;
      logic [SEL_W-1:0]  sel;
      logic              hi_byte;
      logic [DATA_W-1:0] data;
   } twh_hold_wr_t;
endpackage : twh_pkg

// [logic/twh_hold_bank.sv]
// Eight-entry holding register bank feeding flash programming
`timescale 1ns/1ns
module twh_hold_bank #(
   parameter int N = twh_pkg::HOLD_N,
   parameter int W = twh_pkg::DATA_W
) (
   input  wire logic                 core_clk_i,
   input  wire logic                 srst_i,
   input  wire twh_pkg::twh_hold_wr_t wr_i,
   output logic [N-1:0][W-1:0]       hold_o
);
   logic [N-1:0][W-1:0] bank_reg;
   logic [N-1:0][W-1:0] bank_next;

   always_comb
   begin
      bank_next = bank_reg;
      if (wr_i.valid)
      begin
         bank_next[wr_i.sel] = wr_i.data;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         bank_reg <= {N{twh_pkg::HOLD_RST}};
      end
      else
      begin
         bank_reg <= bank_next;
      end
   end

   assign hold_o = bank_reg;
endmodule : twh_hold_bank

// [logic/twh_unit.sv]
// Table write execution: decode, pointer update, holding register write
`timescale 1ns/1ns
module twh_unit #(
   parameter int PTR_W = twh_pkg::PTR_W
) (
   input  wire logic                            core_clk_i,
   input  wire logic                            srst_i,
   input  wire twh_pkg::twh_instr_t             instr_i,
   input  wire logic [twh_pkg::DATA_W-1:0]      table_byte_latch_i,
   input  wire twh_pkg::twh_ptr_load_t          ptr_load_i,
   output logic                                 busy_o,
   output logic                                 hold_wr_o,
   output logic [twh_pkg::SEL_W-1:0]            hold_sel_o,
   output logic                                 hold_hi_byte_o,
   output logic [PTR_W-1:0]                     program_byte_pointer_o,
   output logic [twh_pkg::HOLD_N-1:0][twh_pkg::DATA_W-1:0] hold_o
);
   typedef enum logic [0:0] {TWH_IDLE, TWH_EXEC} twh_state_t;

   function automatic logic is_table_write(input logic [twh_pkg::OPC_W-1:0] op);
      is_table_write = (op & twh_pkg::OPC_MASK) == twh_pkg::OPC_MATCH;
   endfunction : is_table_write

   function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p, input logic up);
      step = up ? p + PTR_W'(twh_pkg::PTR_ONE) : p - PTR_W'(twh_pkg::PTR_ONE);
   endfunction : step

   twh_state_t             state_reg;
   twh_state_t             state_next;
   logic [1:0]             mode_reg;
   logic [1:0]             mode_next;
   logic [PTR_W-1:0]       ptr_reg;
   logic [PTR_W-1:0]       ptr_next;
   logic [PTR_W-1:0]       addr_reg;
   logic [PTR_W-1:0]       addr_next;
   twh_pkg::twh_hold_wr_t  wr_reg;
   twh_pkg::twh_hold_wr_t  wr_next;
   logic                   busy_reg;
   logic                   busy_next;

   always_comb
   begin
      state_next = state_reg;
      mode_next  = mode_reg;
      ptr_next   = ptr_reg;
      addr_next  = addr_reg;
      wr_next    = '0;
      busy_next  = 1'b0;
      case (state_reg)
         TWH_IDLE:
         begin
            if (ptr_load_i.load)
            begin
               ptr_next = ptr_load_i.value;
            end
            if (instr_i.valid && is_table_write(instr_i.opcode))
            begin
               // Decode cycle; EXEC follows, and the holding register write strobe comes in the third cycle
               mode_next  = instr_i.opcode[1:0];
               state_next = TWH_EXEC;
               busy_next  = 1'b1;
               case (instr_i.opcode[1:0])
                  twh_pkg::MODE_NONE:
                  begin
                     addr_next = ptr_reg;
                  end
                  twh_pkg::MODE_PINC:
                  begin
                     addr_next = ptr_reg;
                     ptr_next  = step(ptr_reg, 1'b1);
                  end
                  twh_pkg::MODE_PDEC:
                  begin
                     addr_next = ptr_reg;
                     ptr_next  = step(ptr_reg, 1'b0);
                  end
                  default:
                  begin
                     addr_next = step(ptr_reg, 1'b1);
                     ptr_next  = addr_next;
                  end
               endcase
            end
         end
         TWH_EXEC:
         begin
            // Pointer loads arriving while busy are dropped so the update is not overwritten
            state_next      = TWH_IDLE;
            wr_next.valid   = 1'b1;
            wr_next.sel     = addr_reg[twh_pkg::SEL_W-1:0];
            wr_next.hi_byte = addr_reg[0];
            wr_next.data    = table_byte_latch_i;
         end
         default:
         begin
            state_next = TWH_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         state_reg <= TWH_IDLE;
         mode_reg  <= twh_pkg::MODE_NONE;
         ptr_reg   <= twh_pkg::PTR_RST;
         addr_reg  <= twh_pkg::PTR_RST;
         wr_reg    <= '0;
         busy_reg  <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         mode_reg  <= mode_next;
         ptr_reg   <= ptr_next;
         addr_reg  <= addr_next;
         wr_reg    <= wr_next;
         busy_reg  <= busy_next;
      end
   end

   twh_hold_bank u_bank (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .wr_i       (wr_reg),
      .hold_o     (hold_o)
   );

   assign busy_o                 = busy_reg;
   assign hold_wr_o              = wr_reg.valid;
   assign hold_sel_o             = wr_reg.sel;
   assign hold_hi_byte_o         = wr_reg.hi_byte;
   assign program_byte_pointer_o = ptr_reg;
endmodule : twh_unit

// [verification/twh_unit_sva.sv]
// Assertion checker for the table write unit
`timescale 1ns/1ns
module twh_unit_sva #(
   parameter int PTR_W = twh_pkg::PTR_W
) (
   input wire logic                   core_clk_i,
   input wire logic                   srst_i,
   input wire twh_pkg::twh_instr_t    instr_i,
   input wire logic [7:0]             table_byte_latch_i,
   input wire twh_pkg::twh_ptr_load_t ptr_load_i,
   input wire logic                   busy_o,
   input wire logic                   hold_wr_o,
   input wire logic [2:0]             hold_sel_o,
   input wire logic                   hold_hi_byte_o,
   input wire logic [PTR_W-1:0]       program_byte_pointer_o,
   input wire logic [7:0][7:0]        hold_o
);
   logic [PTR_W-1:0] p;
   logic [1:0]       m;
   logic             a;
   assign p = program_byte_pointer_o;
   assign m = instr_i.opcode[1:0];
   assign a = instr_i.valid && !busy_o
      && (instr_i.opcode & twh_pkg::OPC_MASK) == twh_pkg::OPC_MATCH;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   busy_a: assert property (a |=> busy_o ##1 (!busy_o && hold_wr_o))
      else $error("busy or write pulse wrong");
   dec_a: assert property (instr_i.valid && !busy_o && !a |=> !busy_o)
      else $error("foreign opcode taken");
   pinc_a: assert property (a && m == twh_pkg::MODE_PINC |=> p == $past(p) + twh_pkg::PTR_ONE)
      else $error("post increment wrong");
   pdec_a: assert property (a && m == twh_pkg::MODE_PDEC |=> p == $past(p) - twh_pkg::PTR_ONE)
      else $error("post decrement wrong");
   keep_a: assert property (a && m == twh_pkg::MODE_NONE |=> $stable(p))
      else $error("pointer moved");
   pre_a: assert property (a && m == twh_pkg::MODE_PRE |=> ##1 hold_sel_o == $past(p[2:0]))
      else $error("pre increment slot wrong");
   sel_a: assert property (a && m != twh_pkg::MODE_PRE |-> ##2 hold_sel_o == $past(p[2:0], 2))
      else $error("slot wrong");
   data_a: assert property (hold_wr_o |=> hold_o[$past(hold_sel_o)] == $past(table_byte_latch_i, 2))
      else $error("holding data wrong");
   byte_sel_a: assert property (a && m != twh_pkg::MODE_PRE |-> ##2 hold_hi_byte_o == $past(p[0], 2))
      else $error("byte select wrong");
   pre_byte_a: assert property (a && m == twh_pkg::MODE_PRE |=> ##1 hold_hi_byte_o == $past(p[0]))
      else $error("pre increment byte select wrong");
   cover property (a && m == twh_pkg::MODE_PRE);
   cover property (a && m == twh_pkg::MODE_PDEC);
   cover property (hold_wr_o && hold_hi_byte_o);
endmodule : twh_unit_sva
bind twh_unit twh_unit_sva #(.PTR_W(PTR_W)) u_sva (.*);

// [verification/twh_flash_model.sv]
// Flash programming side: reads one word from the holding bank
`timescale 1ns/1ns
module twh_flash_model (
   input  wire logic            core_clk_i,
   input  wire logic [7:0][7:0] hold_i,
   input  wire logic [1:0]      word_i,
   output logic [15:0]          word_o
);
   always_ff @(posedge core_clk_i)
      word_o <= {hold_i[{word_i, 1'b1}], hold_i[{word_i, 1'b0}]};
endmodule : twh_flash_model

// [verification/tb_top.sv]
// Self-checking bench for the table write unit
`timescale 1ns/1ns
module tb_top;
   logic                   clk = 0;
   logic                   rst = 1;
   twh_pkg::twh_instr_t    ins = '0;
   twh_pkg::twh_ptr_load_t ld = '0;
   logic [7:0]             lat = '0;
   logic                   busy, wr, hi;
   logic [2:0]             sel;
   logic [20:0]            ptr;
   logic [7:0][7:0]        hold;
   logic [15:0]            word;
   int                     error_cnt = 0;
   int                     comparisons = 0;
   always #10 clk = ~clk;
   twh_unit dut (.core_clk_i(clk), .srst_i(rst), .instr_i(ins), .table_byte_latch_i(lat),
      .ptr_load_i(ld), .busy_o(busy), .hold_wr_o(wr), .hold_sel_o(sel),
      .hold_hi_byte_o(hi), .program_byte_pointer_o(ptr), .hold_o(hold));
   twh_flash_model fm (.core_clk_i(clk), .hold_i(hold), .word_i(2'h1), .word_o(word));
   task chk(input string n, input logic [20:0] e, input logic [20:0] s);
      comparisons++;
      if (s !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task op(input logic [20:0] p, input logic [15:0] o, input logic [7:0] d);
      @(posedge clk) ld <= '{1'b1, p};
      @(posedge clk) ld <= '0;
      ins <= '{1'b1, o};
      @(posedge clk) ins <= '0;
      lat <= d;
      repeat (3) @(posedge clk);
      #1;
   endtask : op
   task s_pre;
      op(21'h01389A, 16'h000F, 8'h34);
      chk("ptr", 21'h01389B, ptr);
      chk("slot3", 21'h34, hold[3]);
      chk("word", 21'h34FF, word);
   endtask : s_pre
   task s_pinc;
      op(21'h00A356, 16'h000D, 8'h55);
      chk("ptr", 21'h00A357, ptr);
      chk("slot6", 21'h55, hold[6]);
   endtask : s_pinc
   task s_pdec;
      op(21'h000000, 16'h000E, 8'hA5);
      chk("ptr", 21'h1FFFFF, ptr);
      chk("slot0", 21'hA5, hold[0]);
   endtask : s_pdec
   task s_none;
      op(21'h1FFFF9, 16'h000C, 8'h3C);
      chk("ptr", 21'h1FFFF9, ptr);
      chk("slot1", 21'h3C, hold[1]);
   endtask : s_none
   task s_bad;
      op(21'h000004, 16'h001C, 8'h77);
      chk("ptr", 21'h000004, ptr);
      chk("slot4", 21'hFF, hold[4]);
   endtask : s_bad
   task print_verdict;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 0;
      s_pre;
      s_pinc;
      s_pdec;
      s_none;
      s_bad;
      print_verdict;
   end
   initial
   begin
      #20000;
      error_cnt++;
      print_verdict;
   end
endmodule : tb_top
